// ### srp_cmd_core.sv
// command decode, refresh, power-down, clock suspend and dqm masking
// Function
// [R1] selected with ras, cas, we high is a no-operation; nothing changes
// [R2] burst stop ends a read or write burst without auto precharge
// [R3] read data keeps driving for cas latency cycles after burst stop
// [R4] chip select high ignores ras, cas, we and address
// [R5] auto refresh refreshes the counter row, then increments the counter
// [R6] controller performs all 4096 refreshes every 64 ms
// [R7] controller sends only no-operations until a refresh completes
// [R8] controller refreshes only with banks idle and cke high before
// [R9] controller waits precharge time between refreshes
// [R10] refresh code with cke low enters self refresh, internal timing
// [R11] self refresh lasts while cke low; cke high exits
// [R12] controller sends only nop or deselect for row cycle after exit
// [R13] controller bursts 4096 refreshes around self refresh
// [R14] cke low during a burst masks internal clock, state held
// [R15] cke low with banks idle enters power-down, buffers off
// [R16] controller leaves suspend or power-down within 64 ms
// [R17] cke high resumes internal clock next cycle, buffers back on
// [R18] controller waits one cycle after suspend or power-down exit
// [R19] dqm masks write words and disables read outputs
// [R20] read masking by dqm takes effect two clocks after sampling
// [R21] commands decode only when cke was high the cycle before
`timescale 1ns/1ps
module srp_cmd_core
    import srp_pkg::*;
#(
    parameter int ROWS = REF_ROWS,
    parameter int SELF_INT = REF_INT_CYC,
    parameter int ROW_W = $clog2(ROWS)
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic cke,
    input wire logic dqm,
    input wire logic [1:0] casLatency,
    input wire logic banksIdle,
    input wire logic burstRead,
    input wire logic burstWrite,
    input wire logic burstAutoPre,
    output logic burstStop,
    output logic refreshStrobe,
    output logic [ROW_W-1:0] refreshRow,
    output logic refreshBusy,
    output logic selfRefresh,
    output logic powerDown,
    output logic clockSuspend,
    output logic internalClkEn,
    output logic inputBufEn,
    output logic writeMask,
    output logic dqOutEn
);
    import srp_pkg::*;

    localparam int SELF_W = $clog2(SELF_INT + 1);

    // the row counter wraps by overflow, so rows must be a power of two
    generate
        if (ROWS < 2 || (ROWS & (ROWS - 1)) != 0 || SELF_INT < TRC_CYC || SELF_W > CNT_W) begin : g_bad
            $error("srp_cmd_core: unsupported parameter values");
        end
        if (ROW_W != $clog2(ROWS)) begin : g_bad_width
            $error("srp_cmd_core: row width does not match the row count");
        end
    endgenerate

    srp_state_t state_r, state_nxt;
    logic ckePrev_r, ckePrev_nxt;
    logic [CNT_W-1:0] timer_r, timer_nxt;
    logic [ROW_W-1:0] rowCnt_r, rowCnt_nxt;
    logic [ROW_W-1:0] refreshRow_r, refreshRow_nxt;
    logic refreshStrobe_r, refreshStrobe_nxt;
    logic burstStop_r, burstStop_nxt;
    logic [1:0] drainCnt_r, drainCnt_nxt;
    logic [1:0] dqmPipe_r, dqmPipe_nxt;
    logic dqOutEn_r, dqOutEn_nxt;

    logic [2:0] cmd;
    logic cmdValid;
    logic isNop;
    logic isBst;
    logic isRef;
    logic isSrefEnt;
    logic inBurst;
    logic clkMasked;
    logic rdDrive;

    // timers run down to zero, so a load of n gives n cycles
    function automatic logic [CNT_W-1:0] load_count(input int cycles);
        load_count = CNT_W'(cycles - 1);
    endfunction

    assign cmd = {rasN, casN, weN};
    // deselect and a low cke on the previous edge both block decoding
    assign cmdValid = ckePrev_r && !csN && state_r == ST_IDLE; // [R4] [R21]
    assign isNop = cmdValid && cmd == CMD_NOP; // [R1]
    assign inBurst = burstRead || burstWrite;
    // a stop inside an auto precharge burst is ignored; the precharge owns the end
    assign isBst = cmdValid && cmd == CMD_BST && inBurst && !burstAutoPre; // [R2]
    assign isRef = cmdValid && cmd == CMD_REF && cke; // [R5]
    assign isSrefEnt = cmdValid && cmd == CMD_REF && !cke; // [R10]
    assign clkMasked = state_r == ST_SUSP || state_r == ST_PDWN || state_r == ST_SREF;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        rowCnt_nxt = rowCnt_r;
        refreshRow_nxt = refreshRow_r;
        refreshStrobe_nxt = 1'b0;
        ckePrev_nxt = cke;
        case (state_r)
            ST_IDLE: begin
                if (isRef) begin
                    state_nxt = ST_AREF;
                    timer_nxt = load_count(TRC_CYC);
                    refreshStrobe_nxt = 1'b1; // [R5]
                    refreshRow_nxt = rowCnt_r;
                    rowCnt_nxt = rowCnt_r + 1'b1;
                end else if (isSrefEnt) begin
                    state_nxt = ST_SREF; // [R10]
                    timer_nxt = load_count(SELF_INT);
                end else if (ckePrev_r && !cke) begin
                    if (inBurst) begin
                        state_nxt = ST_SUSP; // [R14]
                    end else if (banksIdle) begin
                        state_nxt = ST_PDWN; // [R15]
                    end
                end
            end
            ST_AREF: begin
                // the controller keeps to nops here, so commands are not looked at
                if (timer_r == '0) begin
                    state_nxt = ST_IDLE;
                end else begin
                    timer_nxt = timer_r - 1'b1;
                end
            end
            ST_SREF: begin
                // internal timer paces refreshes; counter shared with auto refresh
                if (timer_r == '0) begin
                    timer_nxt = load_count(SELF_INT);
                    refreshStrobe_nxt = 1'b1; // [R10]
                    refreshRow_nxt = rowCnt_r;
                    rowCnt_nxt = rowCnt_r + 1'b1;
                end else begin
                    timer_nxt = timer_r - 1'b1;
                end
                if (cke) begin
                    state_nxt = ST_SREX; // [R11]
                    timer_nxt = load_count(TRC_CYC);
                end
            end
            ST_SREX: begin
                // a row refreshed inside may still be running, so wait a full row cycle
                if (timer_r == '0) begin
                    state_nxt = ST_IDLE;
                end else begin
                    timer_nxt = timer_r - 1'b1;
                end
            end
            ST_PDWN, ST_SUSP: begin
                // the wake edge never decodes: ckePrev_r is still low on it
                if (cke) begin
                    state_nxt = ST_IDLE; // [R17]
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_IDLE;
            // starts low so nothing decodes on the first edge after reset
            ckePrev_r <= 1'b0;
            timer_r <= '0;
            rowCnt_r <= '0;
            refreshRow_r <= '0;
            refreshStrobe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ckePrev_r <= ckePrev_nxt;
            timer_r <= timer_nxt;
            rowCnt_r <= rowCnt_nxt;
            refreshRow_r <= refreshRow_nxt;
            refreshStrobe_r <= refreshStrobe_nxt;
        end
    end

    // data path: burst stop, read drain and dqm
    assign rdDrive = burstRead || drainCnt_r != '0;

    always_comb begin
        burstStop_nxt = isBst; // [R2]
        drainCnt_nxt = drainCnt_r;
        if (isBst && burstRead) begin
            drainCnt_nxt = casLatency; // [R3]
        end else if (drainCnt_r != '0 && !clkMasked) begin
            // a suspended clock freezes the drain as well
            drainCnt_nxt = drainCnt_r - 1'b1; // [R14]
        end
        // one stage per clock of read mask latency
        dqmPipe_nxt = {dqmPipe_r[0], dqm}; // [R20]
        dqOutEn_nxt = rdDrive && !dqmPipe_r[DQM_RD_LAT-1] && state_r != ST_PDWN; // [R19] [R20]
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            burstStop_r <= 1'b0;
            drainCnt_r <= '0;
            dqmPipe_r <= '1;
            dqOutEn_r <= 1'b0;
        end else begin
            burstStop_r <= burstStop_nxt;
            drainCnt_r <= drainCnt_nxt;
            dqmPipe_r <= dqmPipe_nxt;
            dqOutEn_r <= dqOutEn_nxt;
        end
    end

    assign burstStop = burstStop_r;
    assign refreshStrobe = refreshStrobe_r;
    assign refreshRow = refreshRow_r;
    // busy covers both the auto refresh row cycle and the self refresh exit
    assign refreshBusy = state_r == ST_AREF || state_r == ST_SREX;
    assign selfRefresh = state_r == ST_SREF;
    assign powerDown = state_r == ST_PDWN;
    assign clockSuspend = state_r == ST_SUSP;
    assign internalClkEn = !clkMasked; // [R14] [R17]
    // clock suspend keeps the buffers on so the held burst resumes at once
    assign inputBufEn = !(state_r == ST_PDWN || state_r == ST_SREF); // [R15]
    // write masking has no latency: the word is blocked on the dqm edge
    assign writeMask = burstWrite && dqm; // [R19]
    assign dqOutEn = dqOutEn_r;

    // all checks share the one clock and the one reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_NOP_IDLE: assert property (isNop && cke |=> state_r == ST_IDLE && !burstStop) // [R1]
        else $error("nop changed state");
    AST_BST_STOP: assert property (cmdValid && cmd == CMD_BST && inBurst && !burstAutoPre |=> burstStop) // [R2]
        else $error("burst stop not issued");
    AST_BST_AP: assert property (cmdValid && burstAutoPre |=> !burstStop) // [R2]
        else $error("burst stop with auto precharge");
    AST_DRAIN: assert property (isBst && burstRead |=> drainCnt_r == $past(casLatency)) // [R3]
        else $error("read drain length wrong");
    AST_DESEL: assert property (csN && state_r == ST_IDLE |=> !burstStop && state_r != ST_AREF && state_r != ST_SREF) // [R4]
        else $error("deselect decoded a command");
    AST_AREF: assert property (isRef |=> refreshStrobe && refreshRow == $past(rowCnt_r) ##0 refreshBusy [*2]) // [R5]
        else $error("auto refresh wrong");
    AST_AREF_LEN: assert property (isRef |=> refreshBusy ##10 refreshBusy ##1 !refreshBusy) // [R5]
        else $error("refresh busy length wrong");
    AST_SREF: assert property (isSrefEnt |=> selfRefresh && !inputBufEn) // [R10]
        else $error("self refresh not entered");
    AST_SREF_HOLD: assert property (selfRefresh && !cke |=> selfRefresh) // [R11]
        else $error("self refresh left with cke low");
    AST_SUSP: assert property (state_r == ST_IDLE && ckePrev_r && !cke && !isSrefEnt && inBurst |=> !internalClkEn && inputBufEn) // [R14]
        else $error("clock suspend not entered");
    AST_PDWN: assert property (state_r == ST_IDLE && ckePrev_r && !cke && !isSrefEnt && !inBurst && banksIdle |=> powerDown && !inputBufEn) // [R15]
        else $error("power-down not entered");
    AST_WAKE: assert property ((powerDown || clockSuspend) && cke |=> internalClkEn && inputBufEn) // [R17]
        else $error("wake not within one cycle");
    AST_DQM_LAT: assert property (dqm |-> ##3 !dqOutEn) // [R20]
        else $error("read mask latency wrong");
    AST_CKE_GATE: assert property (!ckePrev_r && state_r == ST_IDLE |=> !burstStop && state_r != ST_AREF) // [R21]
        else $error("command decoded after low cke");

    // refresh, power states and data path
    AST_ROW_INC: assert property (refreshStrobe |-> rowCnt_r == ROW_W'(refreshRow + 1'b1)) // [R5]
        else $error("row counter not advanced");
    AST_REF_ONE: assert property (refreshStrobe |=> !refreshStrobe) // [R5]
        else $error("refresh strobe longer than one cycle");
    AST_BUSY_QUIET: assert property (refreshBusy |=> !burstStop && !refreshStrobe) // [R5]
        else $error("command taken while refresh busy");
    AST_DESEL_REF: assert property (csN && state_r == ST_IDLE |=> !refreshStrobe && !selfRefresh) // [R4]
        else $error("deselect started a refresh");
    AST_SREF_TICK: assert property (selfRefresh && timer_r == '0 |=> refreshStrobe && refreshRow == $past(rowCnt_r)) // [R10]
        else $error("self refresh tick missing");
    AST_SREX_LEN: assert property (selfRefresh && cke |=> refreshBusy ##10 refreshBusy ##1 !refreshBusy) // [R11]
        else $error("self refresh exit length wrong");
    AST_SUSP_HOLD: assert property (clockSuspend && !cke |=> clockSuspend && drainCnt_r == $past(drainCnt_r)) // [R14]
        else $error("state moved while suspended");
    AST_SUSP_NOCMD: assert property (clockSuspend |=> !refreshStrobe && !burstStop) // [R14]
        else $error("command decoded while suspended");
    AST_PDWN_HOLD: assert property (powerDown && !cke |=> powerDown && !dqOutEn) // [R15]
        else $error("power-down left or output driven");
    AST_PDWN_NOCMD: assert property (powerDown |=> !refreshStrobe && !burstStop) // [R15]
        else $error("command decoded in power-down");
    AST_DRAIN_DEC: assert property (drainCnt_r != '0 && !clkMasked && !isBst |=> drainCnt_r == $past(drainCnt_r) - 1'b1) // [R3]
        else $error("read drain did not count down");
    AST_DRAIN_OUT: assert property (drainCnt_r != '0 && !dqmPipe_r[DQM_RD_LAT-1] && !powerDown |=> dqOutEn) // [R3]
        else $error("read drain not driven");
    AST_WMASK: assert property (burstWrite && dqm |-> writeMask) // [R19]
        else $error("write word not masked");
    AST_WUNMASK: assert property (!dqm |-> !writeMask) // [R19]
        else $error("write word masked without dqm");
endmodule

// ### srp_cmd_core_tb.sv
// testbench for the refresh, power and masking command block
`timescale 1ns/1ps
module srp_cmd_core_tb;
    import srp_pkg::*;
    localparam int ROWS = 8;
    // short self refresh spacing keeps the run brief
    localparam int SELF_INT = 20;
    logic clock, reset, csN, rasN, casN, weN, cke, dqm, banksIdle, burstRead, burstWrite, burstAutoPre;
    logic burstStop, refreshStrobe, refreshBusy, selfRefresh, powerDown, clockSuspend;
    logic internalClkEn, inputBufEn, writeMask, dqOutEn;
    logic [1:0] casLatency;
    logic [2:0] refreshRow, lastRow;
    int errors, checks, cycles, strobes, stops, busyCycles;
    srp_cmd_core #(.ROWS(ROWS), .SELF_INT(SELF_INT)) i_srp_cmd_core (.clock, .reset, .csN, .rasN, .casN,
        .weN, .cke, .dqm, .casLatency, .banksIdle, .burstRead, .burstWrite, .burstAutoPre, .burstStop,
        .refreshStrobe, .refreshRow, .refreshBusy, .selfRefresh, .powerDown, .clockSuspend,
        .internalClkEn, .inputBufEn, .writeMask, .dqOutEn);
    srp_ctrl_model i_srp_ctrl_model (.clock, .refreshBusy, .csN, .rasN, .casN, .weN, .cke);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // pulses are counted at the sampling edge so no check races a one-cycle strobe
    always @(posedge clock) begin
        cycles++;
        if (refreshStrobe === 1'b1) begin
            strobes++;
            lastRow = refreshRow;
        end
        if (burstStop === 1'b1) stops++;
        if (refreshBusy === 1'b1) busyCycles++;
        if (cycles == 4000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        @(negedge clock);
        check({11'h0, refreshBusy, internalClkEn, inputBufEn, dqOutEn, selfRefresh}, 16'h000C);
        check({13'h0, refreshRow}, 16'h0000);
    endtask
    // one more refresh than rows, so the row counter wraps
    task automatic t_aref();
        int s, b;
        @(posedge clock);
        for (int i = 0; i <= ROWS; i++) begin
            s = strobes;
            b = busyCycles;
            i_srp_ctrl_model.send(4'h1, 1'b1);
            i_srp_ctrl_model.settle();
            check(16'(strobes - s), 16'h0001);
            check({13'h0, lastRow}, 16'(i % ROWS));
            check(16'(busyCycles - b), 16'(TRC_CYC));
        end
    endtask
    task automatic t_desel_pdown();
        int s;
        @(posedge clock);
        s = strobes;
        i_srp_ctrl_model.send(4'h9, 1'b1);
        @(posedge clock);
        i_srp_ctrl_model.send(4'h7, 1'b0);
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({14'h0, powerDown, inputBufEn}, 16'h0002);
        @(posedge clock);
        // refresh code on the edge where cke rises must be ignored
        i_srp_ctrl_model.send(4'h1, 1'b1);
        i_srp_ctrl_model.settle();
        @(negedge clock);
        check({14'h0, powerDown, internalClkEn}, 16'h0001);
        check(16'(strobes - s), 16'h0000);
    endtask
    task automatic t_self();
        int s;
        @(posedge clock);
        s = strobes;
        i_srp_ctrl_model.send(4'h1, 1'b0);
        repeat (45) @(posedge clock);
        @(negedge clock);
        check({13'h0, selfRefresh, internalClkEn, inputBufEn}, 16'h0004);
        check(16'(strobes - s), 16'h0002);
        @(posedge clock);
        i_srp_ctrl_model.send(4'h7, 1'b1);
        i_srp_ctrl_model.settle();
        @(negedge clock);
        check({15'h0, selfRefresh}, 16'h0000);
    endtask
    task automatic t_bst(input logic [1:0] cl, input logic autoPre);
        int s;
        @(posedge clock);
        casLatency <= cl;
        burstAutoPre <= autoPre;
        burstRead <= 1'b1;
        repeat (4) @(posedge clock);
        s = stops;
        i_srp_ctrl_model.send(4'h6, 1'b1);
        burstRead <= 1'b0;
        repeat (cl + 1) @(negedge clock);
        if (!autoPre) check({15'h0, dqOutEn}, 16'h0001);
        @(negedge clock);
        check({15'h0, dqOutEn}, 16'h0000);
        check(16'(stops - s), {15'h0, !autoPre});
        @(posedge clock);
        burstAutoPre <= 1'b0;
    endtask
    task automatic t_dqm();
        @(posedge clock);
        burstRead <= 1'b1;
        repeat (4) @(posedge clock);
        dqm <= 1'b1;
        repeat (3) @(negedge clock);
        check({15'h0, dqOutEn}, 16'h0001);
        @(negedge clock);
        check({15'h0, dqOutEn}, 16'h0000);
        @(posedge clock);
        burstRead <= 1'b0;
        burstWrite <= 1'b1;
        @(negedge clock);
        check({15'h0, writeMask}, 16'h0001);
        @(posedge clock);
        dqm <= 1'b0;
        @(negedge clock);
        check({15'h0, writeMask}, 16'h0000);
        @(posedge clock);
        burstWrite <= 1'b0;
    endtask
    task automatic t_susp();
        @(posedge clock);
        burstRead <= 1'b1;
        i_srp_ctrl_model.send(4'h7, 1'b0);
        repeat (2) @(negedge clock);
        check({13'h0, clockSuspend, internalClkEn, inputBufEn}, 16'h0005);
        @(posedge clock);
        i_srp_ctrl_model.send(4'h7, 1'b1);
        repeat (2) @(negedge clock);
        check({13'h0, clockSuspend, internalClkEn, powerDown}, 16'h0002);
        @(posedge clock);
        burstRead <= 1'b0;
    endtask
    initial begin
        reset = 1'b1;
        dqm = 1'b0;
        banksIdle = 1'b1;
        burstRead = 1'b0;
        burstWrite = 1'b0;
        burstAutoPre = 1'b0;
        casLatency = 2'h2;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        repeat (2) @(posedge clock);
        t_desel_pdown();
        // a full row burst just before self refresh entry
        t_aref();
        t_self();
        t_bst(2'h2, 1'b0);
        t_bst(2'h3, 1'b0);
        t_bst(2'h3, 1'b1);
        t_dqm();
        t_susp();
        finish_test();
    end
endmodule

// ### srp_ctrl_model.sv
// controller model that drives the command pins of the block
`timescale 1ns/1ps
module srp_ctrl_model (
    input wire logic clock,
    input wire logic refreshBusy,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic cke
);
    import srp_pkg::*;
    initial begin
        {csN, rasN, casN, weN, cke} = 5'h1F;
    end
    // one command cycle, then a selected nop so idle cycles never decode as a command
    task automatic send(input logic [3:0] cmd, input logic ck);
        {csN, rasN, casN, weN} <= cmd;
        cke <= ck;
        @(posedge clock);
        {csN, rasN, casN, weN} <= {1'b0, CMD_NOP};
    endtask
    // nops only until the refresh or exit is over, then one spare cycle
    task automatic settle();
        // busy shows only one edge after the command, so look from the next edge on
        @(posedge clock);
        for (int n = 0; n < 40 && refreshBusy !== 1'b0; n++) begin
            @(posedge clock);
        end
        @(posedge clock);
    endtask
endmodule

// ### srp_pkg.sv
// constants and types for the refresh, power and masking command block
package srp_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TRC_MIN_NS = 55;
    localparam int TRC_CYC = (TRC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_PERIOD_NS = 64000000;
    localparam int REF_ROWS = 4096;
    // longest spacing of self refresh pulses, rounded down
    localparam int REF_INT_CYC = REF_PERIOD_NS / REF_ROWS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int DQM_RD_LAT = 2;
    localparam logic [1:0] CL_MIN = 2'h2;
    localparam logic [1:0] CL_MAX = 2'h3;
    // command code is {rasN, casN, weN}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_REF = 3'h1;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_AREF = 6'h02,
        ST_SREF = 6'h04,
        ST_SREX = 6'h08,
        ST_PDWN = 6'h10,
        ST_SUSP = 6'h20
    } srp_state_t;
endpackage
